/* mlf_pkg.sv */
package mlf_pkg;

    // ********************************************************
    // register map (plain port, byte offsets as decoded)
    // ********************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_FAULT_FIRST = 8'h90;
    localparam logic [ADDR_W-1:0] OFS_FAULT_SECOND = 8'h92;
    localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 8'hA0;
    localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 8'hA4;
    localparam logic [ADDR_W-1:0] OFS_DET_STATE = 8'hA8;

    localparam logic [DATA_W-1:0] RST_FAULT_SECOND = 32'h00000000;
    localparam logic [1:0] RST_FAULT_FIRST = 2'h0;
    localparam logic [4:0] RST_EVT = 5'h00;

    // ********************************************************
    // fault_settings_first field positions
    // ********************************************************
    localparam int POS_SAT_EN = 0;
    localparam int POS_IPD_FREQ_EN = 1;

    // ********************************************************
    // fault_settings_second field positions
    // ********************************************************
    localparam int POS_RESERVED = 31;
    localparam int POS_SPEED_LOCK_EN = 30;
    localparam int POS_BEMF_LOCK_EN = 29;
    localparam int POS_NOMOTOR_LOCK_EN = 28;
    localparam int POS_SPEED_THR_LSB = 25;
    localparam int POS_BEMF_THR_LSB = 22;
    localparam int POS_CUR_THR_LSB = 19;
    localparam int THR_W = 3;

    // ********************************************************
    // event bits (status, mask and detector state share layout)
    // ********************************************************
    localparam int EVT_SPEED_LOCK = 0;
    localparam int EVT_BEMF_LOCK = 1;
    localparam int EVT_NOMOTOR_LOCK = 2;
    localparam int EVT_IPD_FREQ = 3;
    localparam int EVT_SAT = 4;
    localparam int EVT_W = 5;
    localparam int NUM_LOCK = 3;

    // ********************************************************
    // thresholds
    // ********************************************************
    localparam int MEAS_W = 16;
    localparam logic [7:0] SPD_PCT_BASE = 8'h82;
    localparam logic [7:0] SPD_PCT_STEP = 8'h0A;
    localparam logic [7:0] PCT_SCALE = 8'h64;
    localparam logic [15:0] PERMILLE_SCALE = 16'h03E8;

    // percent of maximum speed, codes 0..7 give 130..200
    function automatic logic [7:0] speed_pct(input logic [THR_W-1:0] code);
        speed_pct = SPD_PCT_BASE + 8'(SPD_PCT_STEP * {5'h00, code});
    endfunction

    // per mille of expected back-EMF
    function automatic logic [15:0] bemf_permille(input logic [THR_W-1:0] code);
        unique case (code)
            3'h0: bemf_permille = 16'h0190;
            3'h1: bemf_permille = 16'h01C2;
            3'h2: bemf_permille = 16'h01F4;
            3'h3: bemf_permille = 16'h0226;
            3'h4: bemf_permille = 16'h0258;
            3'h5: bemf_permille = 16'h028A;
            3'h6: bemf_permille = 16'h02A3;
            3'h7: bemf_permille = 16'h02BC;
        endcase
    endfunction

    // phase current in 0.1 mA units
    function automatic logic [MEAS_W-1:0] nomotor_current(input logic [THR_W-1:0] code);
        unique case (code)
            3'h0: nomotor_current = 16'h01D4;
            3'h1: nomotor_current = 16'h01D4;
            3'h2: nomotor_current = 16'h0271;
            3'h3: nomotor_current = 16'h030C;
            3'h4: nomotor_current = 16'h0618;
            3'h5: nomotor_current = 16'h0C30;
            3'h6: nomotor_current = 16'h1248;
            3'h7: nomotor_current = 16'h186A;
        endcase
    endfunction

endpackage

/* mlf_det_if.sv */
`timescale 1ns/1ns
interface mlf_det_if;
    import mlf_pkg::*;
    logic [NUM_LOCK-1:0] lock_en;
    logic [THR_W-1:0] speed_code;
    logic [THR_W-1:0] bemf_code;
    logic [THR_W-1:0] cur_code;
    logic [MEAS_W-1:0] speed;
    logic [MEAS_W-1:0] max_speed;
    logic [MEAS_W-1:0] bemf;
    logic [MEAS_W-1:0] exp_bemf;
    logic [MEAS_W-1:0] current;
    logic [NUM_LOCK-1:0] hit;

    modport cfg (
        output lock_en, speed_code, bemf_code, cur_code,
        output speed, max_speed, bemf, exp_bemf, current,
        input hit
    );
    modport det (
        input lock_en, speed_code, bemf_code, cur_code,
        input speed, max_speed, bemf, exp_bemf, current,
        output hit
    );
endinterface

/* mlf_lock_detect.sv */
`timescale 1ns/1ns
module mlf_lock_detect
    import mlf_pkg::*;
#(
    parameter int DEB_CYC = 16
) (
    input wire logic clk, // core clock
    input wire logic rst_n, // async reset, active low
    mlf_det_if.det det // configuration, measurements, hits
);

    localparam int CNT_W = $clog2(DEB_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(DEB_CYC);

    // refused at elaboration: a zero-length filter would lock on one noisy sample
    if (DEB_CYC < 1) begin : g_deb_check
        $error("DEB_CYC must be at least 1");
    end

    typedef struct packed {
        logic [NUM_LOCK-1:0][CNT_W-1:0] cnt;
        logic [NUM_LOCK-1:0] hit;
    } mlf_det_st_t;

    mlf_det_st_t st_r;
    mlf_det_st_t st_nxt;
    logic [NUM_LOCK-1:0] cond;
    logic [31:0] spd_lhs;
    logic [31:0] spd_rhs;
    logic [31:0] bemf_lhs;
    logic [31:0] bemf_rhs;

    // ********************************************************
    // threshold comparisons, cross-multiplied to avoid dividers
    // ********************************************************
    always_comb begin
        spd_lhs = 32'(det.speed) * 32'(PCT_SCALE);
        spd_rhs = 32'(det.max_speed) * 32'(speed_pct(det.speed_code));
        bemf_lhs = 32'(det.bemf) * 32'(PERMILLE_SCALE);
        bemf_rhs = 32'(det.exp_bemf) * 32'(bemf_permille(det.bemf_code));
        cond[EVT_SPEED_LOCK] = det.lock_en[EVT_SPEED_LOCK] && (spd_lhs > spd_rhs);
        cond[EVT_BEMF_LOCK] = det.lock_en[EVT_BEMF_LOCK] && (bemf_lhs < bemf_rhs);
        cond[EVT_NOMOTOR_LOCK] = det.lock_en[EVT_NOMOTOR_LOCK]
            && (det.current < nomotor_current(det.cur_code));
    end

    // ********************************************************
    // persistence filter: a lock needs DEB_CYC consecutive samples
    // ********************************************************
    always_comb begin
        st_nxt = st_r;
        for (int i = 0; i < NUM_LOCK; i++) begin
            if (!cond[i]) begin
                st_nxt.cnt[i] = '0;
                st_nxt.hit[i] = 1'b0;
            end else if (st_r.cnt[i] != CNT_MAX) begin
                st_nxt.cnt[i] = st_r.cnt[i] + CNT_W'(1);
                st_nxt.hit[i] = (st_r.cnt[i] + CNT_W'(1)) == CNT_MAX;
            end else begin
                st_nxt.hit[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign det.hit = st_r.hit;

endmodule

/* mlf_top.sv */
// Chosen here: the strobed register port.
`timescale 1ns/1ns
// ********************************************************
// motor lock and fault configuration
// ********************************************************
module mlf_top
    import mlf_pkg::*;
#(
    parameter int LOCK_DEB_CYC = 16
) (
    CLOCK, // 50 MHz core clock
    RST_N, // async reset, active low
    ADDR, // register address
    WDATA, // register write data
    WR, // write strobe
    RD, // read strobe
    RDATA, // read data, valid the cycle after RD
    IRQ, // level interrupt
    SPEED, // measured speed
    MAX_SPEED, // configured maximum speed
    BEMF, // measured back-EMF
    EXP_BEMF, // expected back-EMF
    PHASE_CURRENT, // phase current, 0.1 mA units
    IPD_FREQ_ERR, // raw position-detect frequency error
    CUR_LOOP_SAT, // raw current loop saturation
    SPD_LOOP_SAT, // raw speed loop saturation
    LOCK_DET, // per detector lock flags
    MOTOR_LOCK_FAULT, // any lock detected
    IPD_FREQ_FAULT, // reported frequency fault
    SAT_IND // saturation indication
);
    input wire logic CLOCK;
    input wire logic RST_N;
    input wire logic [ADDR_W-1:0] ADDR;
    input wire logic [DATA_W-1:0] WDATA;
    input wire logic WR;
    input wire logic RD;
    output logic [DATA_W-1:0] RDATA;
    output logic IRQ;
    input wire logic [MEAS_W-1:0] SPEED;
    input wire logic [MEAS_W-1:0] MAX_SPEED;
    input wire logic [MEAS_W-1:0] BEMF;
    input wire logic [MEAS_W-1:0] EXP_BEMF;
    input wire logic [MEAS_W-1:0] PHASE_CURRENT;
    input wire logic IPD_FREQ_ERR;
    input wire logic CUR_LOOP_SAT;
    input wire logic SPD_LOOP_SAT;
    output logic [NUM_LOCK-1:0] LOCK_DET;
    output logic MOTOR_LOCK_FAULT;
    output logic IPD_FREQ_FAULT;
    output logic SAT_IND;

    typedef struct packed {
        logic [1:0] fault_first;
        logic [DATA_W-2:0] fault_second;
        logic [EVT_W-1:0] sts;
        logic [EVT_W-1:0] mask;
        logic [DATA_W-1:0] rdata;
        logic irq;
        logic [NUM_LOCK-1:0] lock;
        logic lock_any;
        logic ipd_fault;
        logic sat_ind;
    } mlf_top_st_t;

    mlf_top_st_t st_r;
    mlf_top_st_t st_nxt;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] det_state;
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] second_full;
    logic ipd_now;
    logic sat_now;

    mlf_det_if dif ();

    // ********************************************************
    // detector hookup
    // ********************************************************
    assign dif.lock_en[EVT_SPEED_LOCK] = st_r.fault_second[POS_SPEED_LOCK_EN];
    assign dif.lock_en[EVT_BEMF_LOCK] = st_r.fault_second[POS_BEMF_LOCK_EN];
    assign dif.lock_en[EVT_NOMOTOR_LOCK] = st_r.fault_second[POS_NOMOTOR_LOCK_EN];
    assign dif.speed_code = st_r.fault_second[POS_SPEED_THR_LSB +: THR_W];
    assign dif.bemf_code = st_r.fault_second[POS_BEMF_THR_LSB +: THR_W];
    assign dif.cur_code = st_r.fault_second[POS_CUR_THR_LSB +: THR_W];
    assign dif.speed = SPEED;
    assign dif.max_speed = MAX_SPEED;
    assign dif.bemf = BEMF;
    assign dif.exp_bemf = EXP_BEMF;
    assign dif.current = PHASE_CURRENT;

    mlf_lock_detect #(
        .DEB_CYC(LOCK_DEB_CYC)
    ) u_det (
        .clk(CLOCK),
        .rst_n(RST_N),
        .det(dif)
    );

    // ********************************************************
    // events and read mux
    // ********************************************************
    always_comb begin
        ipd_now = IPD_FREQ_ERR && st_r.fault_first[POS_IPD_FREQ_EN];
        sat_now = (CUR_LOOP_SAT || SPD_LOOP_SAT) && st_r.fault_first[POS_SAT_EN];
        det_state = {st_r.sat_ind, st_r.ipd_fault, st_r.lock};
        // events are rising edges of the registered indications
        evt = {sat_now && !st_r.sat_ind, ipd_now && !st_r.ipd_fault, dif.hit & ~st_r.lock};
        second_full = {1'b0, st_r.fault_second};
        unique case (ADDR)
            OFS_FAULT_FIRST: rd_mux = {30'h00000000, st_r.fault_first};
            OFS_FAULT_SECOND: rd_mux = second_full;
            OFS_EVT_STATUS: rd_mux = {27'h0000000, st_r.sts};
            OFS_EVT_MASK: rd_mux = {27'h0000000, st_r.mask};
            OFS_DET_STATE: rd_mux = {27'h0000000, det_state};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // ********************************************************
    // next state
    // ********************************************************
    always_comb begin
        st_nxt = st_r;
        if (WR) begin
            unique case (ADDR)
                OFS_FAULT_FIRST: st_nxt.fault_first = WDATA[1:0];
                OFS_FAULT_SECOND: st_nxt.fault_second = WDATA[DATA_W-2:0];
                OFS_EVT_MASK: st_nxt.mask = WDATA[EVT_W-1:0];
                default: st_nxt.fault_first = st_r.fault_first;
            endcase
        end
        st_nxt.rdata = RD ? rd_mux : 32'h00000000;
        // a read clears, but an event in the same cycle still lands
        if (RD && (ADDR == OFS_EVT_STATUS)) begin
            st_nxt.sts = evt;
        end else begin
            st_nxt.sts = st_r.sts | evt;
        end
        st_nxt.lock = dif.hit;
        st_nxt.lock_any = |dif.hit;
        st_nxt.ipd_fault = ipd_now;
        st_nxt.sat_ind = sat_now;
        st_nxt.irq = |(st_nxt.sts & st_nxt.mask);
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            st_r.fault_first <= RST_FAULT_FIRST;
            st_r.fault_second <= RST_FAULT_SECOND[DATA_W-2:0];
            st_r.sts <= RST_EVT;
            st_r.mask <= RST_EVT;
            st_r.rdata <= 32'h00000000;
            st_r.irq <= 1'b0;
            st_r.lock <= '0;
            st_r.lock_any <= 1'b0;
            st_r.ipd_fault <= 1'b0;
            st_r.sat_ind <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ********************************************************
    // outputs, all straight from flops
    // ********************************************************
    assign RDATA = st_r.rdata;
    assign IRQ = st_r.irq;
    assign LOCK_DET = st_r.lock;
    assign MOTOR_LOCK_FAULT = st_r.lock_any;
    assign IPD_FREQ_FAULT = st_r.ipd_fault;
    assign SAT_IND = st_r.sat_ind;

endmodule

/* mlf_top_monitor.sv */
`timescale 1ns/1ns
module mlf_top_monitor
    import mlf_pkg::*;
#(
    parameter int LOCK_DEB_CYC = 16
) (
    input wire logic CLOCK, // core clock
    input wire logic RST_N, // async reset, active low
    input wire logic [ADDR_W-1:0] ADDR, // address
    input wire logic WR, // write strobe
    input wire logic RD, // read strobe
    input wire logic [DATA_W-1:0] RDATA, // read data
    input wire logic IRQ, // interrupt
    input wire logic [MEAS_W-1:0] SPEED, // speed
    input wire logic [MEAS_W-1:0] MAX_SPEED, // max speed
    input wire logic IPD_FREQ_ERR, // raw freq error
    input wire logic CUR_LOOP_SAT, // raw current sat
    input wire logic SPD_LOOP_SAT, // raw speed sat
    input wire logic [NUM_LOCK-1:0] LOCK_DET, // lock flags
    input wire logic MOTOR_LOCK_FAULT, // any lock
    input wire logic IPD_FREQ_FAULT, // freq fault
    input wire logic SAT_IND // saturation
);
    logic over_min;
    logic [7:0] over_cnt;
    logic [EVT_W-1:0] ind;
    // 130 percent is the lowest code, so no speed lock can exist without it
    assign over_min = 32'(SPEED) * 32'h64 > 32'(MAX_SPEED) * 32'h82;
    assign ind = {SAT_IND, IPD_FREQ_FAULT, LOCK_DET};
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            over_cnt <= 8'h00;
        end else if (!over_min) begin
            over_cnt <= 8'h00;
        end else if (over_cnt != 8'hFF) begin
            over_cnt <= over_cnt + 8'h01;
        end
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == '0)
        else $error("read data outside answer cycle");
    a_reserved_zero: assert property ($past(RD) && $past(ADDR) == OFS_FAULT_SECOND |-> !RDATA[POS_RESERVED])
        else $error("reserved bit read as one");
    a_unmapped_zero: assert property ($past(RD) && !($past(ADDR) inside {8'h90, 8'h92, 8'hA0, 8'hA4, 8'hA8})
        |-> RDATA == '0)
        else $error("unmapped read not zero");
    a_speed_debounce: assert property ($rose(LOCK_DET[0]) |-> over_cnt >= 8'(LOCK_DEB_CYC))
        else $error("speed lock before debounce");
    a_speed_drop: assert property (!over_min |-> ##2 !LOCK_DET[0])
        else $error("speed lock held without crossing");
    a_lock_any: assert property (MOTOR_LOCK_FAULT == (LOCK_DET != '0))
        else $error("lock without fault");
    a_fault_cause: assert property (MOTOR_LOCK_FAULT |-> LOCK_DET != '0 || $past(LOCK_DET) != '0)
        else $error("fault without lock");
    a_ipd_gated: assert property (IPD_FREQ_FAULT |-> $past(IPD_FREQ_ERR))
        else $error("freq fault without error");
    a_sat_gated: assert property (SAT_IND |-> $past(CUR_LOOP_SAT || SPD_LOOP_SAT))
        else $error("saturation without cause");
    a_irq_cause: assert property ($rose(IRQ) && !$past(WR) |-> ind != '0 || $past(ind) != '0)
        else $error("interrupt without event");
    c_speed_lock: cover property ($rose(LOCK_DET[0]));
    c_irq: cover property ($rose(IRQ));
    c_freq_fault: cover property ($rose(IPD_FREQ_FAULT) && SAT_IND);
endmodule
bind mlf_top mlf_top_monitor #(.LOCK_DEB_CYC(LOCK_DEB_CYC)) u_mon (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR),
    .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .SPEED(SPEED), .MAX_SPEED(MAX_SPEED), .IPD_FREQ_ERR(IPD_FREQ_ERR),
    .CUR_LOOP_SAT(CUR_LOOP_SAT), .SPD_LOOP_SAT(SPD_LOOP_SAT), .LOCK_DET(LOCK_DET),
    .MOTOR_LOCK_FAULT(MOTOR_LOCK_FAULT), .IPD_FREQ_FAULT(IPD_FREQ_FAULT), .SAT_IND(SAT_IND));

/* motor_lock_fault_config_bench.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; $display("Error %0t: got %h want %h", $time, g, e); end end
module motor_lock_fault_config_bench;
    import mlf_pkg::*;
    localparam int DEB = 3;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [MEAS_W-1:0] spd = '0, max_spd = 16'h0064, bemf = 16'hFFFF, exp_bemf = 16'h03E8, cur = 16'hFFFF;
    logic ipd_err = 1'b0, cur_sat = 1'b0, spd_sat = 1'b0;
    logic [DATA_W-1:0] rdata, want, d;
    logic irq, mlf, ipd_flt, sat;
    logic [NUM_LOCK-1:0] lock_det;
    logic rd_d = 1'b0;
    logic [DATA_W-1:0] exp_q[$];
    logic [15:0] btbl[8] = '{16'h0190, 16'h01C2, 16'h01F4, 16'h0226, 16'h0258, 16'h028A, 16'h02A3, 16'h02BC};
    logic [15:0] ctbl[8] = '{16'h01D4, 16'h01D4, 16'h0271, 16'h030C, 16'h0618, 16'h0C30, 16'h1248, 16'h186A};
    logic [15:0] pct;
    int num_errors = 0;
    int num_checks = 0;
    int seed;
    always #10 clock = ~clock;
    mlf_top #(.LOCK_DEB_CYC(DEB)) u_dut (.CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .IRQ(irq), .SPEED(spd), .MAX_SPEED(max_spd), .BEMF(bemf), .EXP_BEMF(exp_bemf),
        .PHASE_CURRENT(cur), .IPD_FREQ_ERR(ipd_err), .CUR_LOOP_SAT(cur_sat), .SPD_LOOP_SAT(spd_sat),
        .LOCK_DET(lock_det), .MOTOR_LOCK_FAULT(mlf), .IPD_FREQ_FAULT(ipd_flt), .SAT_IND(sat));
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    // the note goes in before the strobe so the watcher always finds it
    task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clock);
        exp_q.push_back(e);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
    endtask
    task automatic set_meas(input int k, input logic [15:0] v);
        case (k)
            0: spd <= v;
            1: bemf <= v;
            default: cur <= v;
        endcase
    endtask
    task automatic lock_case(input int k, input logic [2:0] c, input logic [15:0] thr, input logic [15:0] hitv);
        @(posedge clock);
        set_meas(k, hitv);
        wr_reg(OFS_FAULT_SECOND, (32'h1 << (POS_SPEED_LOCK_EN - k)) | (32'(c) << (POS_SPEED_THR_LSB - 3 * k)));
        cyc(DEB + 3);
        #1;
        `CHK({mlf, lock_det}, {1'b1, 3'(1 << k)})
        rd_reg(OFS_EVT_STATUS, 32'(1 << k));
        rd_reg(OFS_DET_STATE, 32'(1 << k));
        @(posedge clock);
        set_meas(k, thr);
        cyc(4);
        #1;
        `CHK({mlf, lock_det}, 4'h0)
        @(posedge clock);
        set_meas(k, (k == 0) ? 16'h0000 : 16'hFFFF);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ********************************************************
    // read answer watcher
    // ********************************************************
    always @(posedge clock) begin
        #1;
        if (rd_d) begin
            want = exp_q.pop_front();
            `CHK(rdata, want)
        end
        rd_d = rd;
    end
    initial begin
        cyc(20000);
        num_errors++;
        complete_run();
    end
    // ********************************************************
    // main sequence
    // ********************************************************
    initial begin
        seed = $urandom(32'h859A2285);
        cyc(8);
        rst_n <= 1'b1;
        foreach (btbl[i]) rd_reg(8'h90 + 8'(2 * i), 32'h0);
        $display("test 1 done");
        wr_reg(OFS_FAULT_SECOND, 32'hFFFFFFFF);
        rd_reg(OFS_FAULT_SECOND, 32'h7FFFFFFF);
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            wr_reg(OFS_FAULT_SECOND, d);
            rd_reg(OFS_FAULT_SECOND, d & 32'h7FFFFFFF);
        end
        wr_reg(8'h94, 32'hFFFFFFFF);
        rd_reg(8'h94, 32'h0);
        rd_reg(OFS_FAULT_SECOND, d & 32'h7FFFFFFF);
        wr_reg(OFS_FAULT_SECOND, 32'h0);
        $display("test 2 done");
        @(posedge clock);
        ipd_err <= 1'b1;
        cur_sat <= 1'b1;
        @(posedge clock);
        ipd_err <= 1'b0;
        cur_sat <= 1'b0;
        #1;
        `CHK({ipd_flt, sat}, 2'b00)
        wr_reg(OFS_FAULT_FIRST, 32'h3);
        rd_reg(OFS_FAULT_FIRST, 32'h3);
        @(posedge clock);
        ipd_err <= 1'b1;
        spd_sat <= 1'b1;
        @(posedge clock);
        ipd_err <= 1'b0;
        spd_sat <= 1'b0;
        #1;
        `CHK({ipd_flt, sat}, 2'b11)
        cyc(2);
        #1;
        `CHK(irq, 1'b0)
        rd_reg(OFS_EVT_STATUS, 32'h18);
        rd_reg(OFS_EVT_STATUS, 32'h0);
        wr_reg(OFS_EVT_MASK, 32'h08);
        rd_reg(OFS_EVT_MASK, 32'h08);
        @(posedge clock);
        ipd_err <= 1'b1;
        @(posedge clock);
        ipd_err <= 1'b0;
        cyc(3);
        #1;
        `CHK(irq, 1'b1)
        rd_reg(OFS_EVT_STATUS, 32'h08);
        cyc(1);
        #1;
        `CHK(irq, 1'b0)
        $display("test 3 done");
        for (int c = 0; c < 8; c++) begin
            pct = 16'h0082 + 16'h000A * 16'(c);
            lock_case(0, 3'(c), pct, pct + 16'h0001);
            lock_case(1, 3'(c), btbl[c], btbl[c] - 16'h0001);
            lock_case(2, 3'(c), ctbl[c], ctbl[c] - 16'h0001);
        end
        $display("test 4 done");
        // every measurement past any threshold, yet all detectors off
        @(posedge clock);
        spd <= 16'h00FF;
        bemf <= 16'h0000;
        cur <= 16'h0000;
        wr_reg(OFS_FAULT_SECOND, 32'h0FF80000);
        cyc(DEB + 4);
        #1;
        `CHK({mlf, lock_det}, 4'h0)
        rd_reg(OFS_EVT_STATUS, 32'h0);
        // let the watcher take the last answer before the verdict
        cyc(2);
        $display("test 5 done");
        complete_run();
    end
endmodule
